//--- core/serial_mode_pkg.sv
// constants shared by the serial mode control unit
// Overview of operation
// (RULE_01) mode field 000, 001 or 010 makes the unit an SPI master clocking at system/4, /16 or /64.
// (RULE_02) mode 011 is SPI master on the sub clock, 100 is SPI master at half the timer match rate.
// (RULE_03) mode 101 is SPI slave clocked by the peer, 110 is I2C slave, 111 has no function.
// (RULE_04) a set UART select bit hands pins to the UART, otherwise the mode field picks SPI or I2C.
// (RULE_05) the debounce field in control bits 3 to 2 acts only in I2C configuration.
// (RULE_06) a clear interface enable bit takes all function and power away from the serial pins.
// (RULE_07) enabling in SPI configuration leaves every SPI control setting as it was.
// (RULE_08) enabling in I2C configuration keeps transmit select and ack control but resets the flags.
// (RULE_09) the SPI incomplete flag is readable and writable and reads 1 after an incomplete transfer.
// (RULE_10) a slave select rising mid-transfer in slave mode sets incomplete and transfer complete.
// (RULE_11) software writing the incomplete flag to 1 never sets the transfer complete flag.
// (RULE_12) the slave select pin works only while its enable bit is 1 and floats otherwise.
package serial_mode_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_AUX = 8'h04;
	localparam logic [7:0] OFF_I2C = 8'h08;
	localparam logic [7:0] OFF_INT_STATUS = 8'h0C;
	localparam logic [7:0] OFF_INT_MASK = 8'h10;
	// serial_operating_control fields
	localparam int MODE_LSB = 5;
	localparam int UART_BIT = 4;
	localparam int DEB_LSB = 2;
	localparam int EN_BIT = 1;
	localparam int INC_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'hE0;
	// auxiliary control fields
	localparam int SSEN_BIT = 0;
	localparam int TRF_BIT = 1;
	localparam int START_BIT = 2;
	localparam logic [1:0] AUX_RESET = 2'h0;
	// i2c settings and flags
	localparam int TXS_BIT = 0;
	localparam int ACK_BIT = 1;
	localparam int FLAG_LSB = 2;
	localparam int I2C_FLAG_N = 5;
	localparam logic [1:0] I2C_SET_RESET = 2'h0;
	localparam logic [4:0] I2C_FLAG_RESET = 5'h00;
	// interrupt bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_INC = 1;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	// operating modes
	localparam logic [2:0] MODE_DIV4 = 3'h0;
	localparam logic [2:0] MODE_DIV16 = 3'h1;
	localparam logic [2:0] MODE_DIV64 = 3'h2;
	localparam logic [2:0] MODE_SUB = 3'h3;
	localparam logic [2:0] MODE_TIMER = 3'h4;
	localparam logic [2:0] MODE_SLAVE = 3'h5;
	localparam logic [2:0] MODE_I2C = 3'h6;
	// serial clock half periods in system clocks
	localparam logic [5:0] HALF_DIV4 = 6'h02;
	localparam logic [5:0] HALF_DIV16 = 6'h08;
	localparam logic [5:0] HALF_DIV64 = 6'h20;
	localparam logic [3:0] BITS_PER_XFER = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {XFER_IDLE, XFER_MASTER, XFER_SLAVE} xfer_state_t;
endpackage : serial_mode_pkg

//--- core/sync_two_ff.sv
// two flip-flop synchroniser for pin inputs
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;

	// a zero-width synchroniser has nothing to carry
	if (WIDTH < 1)
	begin : g_bad_width
		$error("WIDTH must be at least 1");
	end

	// first stage feeds only the second stage
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_r <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule : sync_two_ff

//--- core/spi_clock_gen.sv
// master serial clock generator with selectable source
module spi_clock_gen
	import serial_mode_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic [2:0] mode,
	input wire logic sub_level,
	input wire logic match_pulse,
	output logic sclk_r,
	output logic bit_done
);
	logic [5:0] cnt_r;
	logic [5:0] half;
	logic sub_q_r;
	logic tick;

	// half period for the divided system clock modes
	always_comb
	begin
		unique case (mode)
			MODE_DIV16: half = HALF_DIV16;
			MODE_DIV64: half = HALF_DIV64;
			default: half = HALF_DIV4;
		endcase
	end

	// sub clock follows its edges, timer toggles once per match: half the match rate
	always_comb
	begin
		if (mode == MODE_SUB)
			tick = run && (sub_level != sub_q_r); // RULE_02
		else if (mode == MODE_TIMER)
			tick = run && match_pulse; // RULE_02
		else
			tick = run && (cnt_r == half - 6'h01); // RULE_01
	end

	assign bit_done = tick && sclk_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sub_q_r <= 1'b0;
		else
			sub_q_r <= sub_level;
	end

	// counter restarts on every toggle so each half period is exact
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run)
		begin
			cnt_r <= 6'h00;
			sclk_r <= 1'b0;
		end
		else if (tick)
		begin
			cnt_r <= 6'h00;
			sclk_r <= !sclk_r;
		end
		else
			cnt_r <= cnt_r + 6'h01;
	end
endmodule : spi_clock_gen

//--- core/serial_mode_ctrl.sv
// serial mode control unit with AXI4-Lite register access
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
module serial_mode_ctrl #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	input wire logic slave_select_pin_in,
	output logic slave_select_pin_out,
	output logic slave_select_pin_oe,
	input wire logic sub_clock_in,
	input wire logic period_match_pulse,
	input wire logic [serial_mode_pkg::I2C_FLAG_N-1:0] i2c_flag_set,
	output logic uart_mode,
	output logic unit_power_on,
	output logic i2c_mode_active,
	output logic [1:0] i2c_debounce,
	output logic irq
);
	import serial_mode_pkg::*;

	// the register decode reads address bits 7:2, so narrower buses cannot be served
	if (ADDR_W < 8 || ADDR_W > 32)
	begin : g_bad_addr_w
		$error("ADDR_W must lie between 8 and 32");
	end

	logic aw_have_r, w_have_r;
	logic [7:0] awaddr_r;
	logic [7:0] wdata_r;
	logic wlane_r;
	logic [7:0] ctrl_r;
	logic [1:0] aux_r;
	logic [1:0] i2c_set_r;
	logic [I2C_FLAG_N-1:0] i2c_flag_r;
	logic [1:0] int_status_r, int_mask_r;
	logic en_q_r;
	xfer_state_t state_r;
	logic [3:0] bit_cnt_r;
	logic [2:0] pins_sync;
	logic sck_q_r;
	logic gen_sclk, gen_bit_done;
	logic wr_fire, wr_ok, wr_ctrl, wr_aux, wr_i2c, wr_int, wr_mask;
	logic [7:0] rd_addr;
	logic rd_hit;
	logic [7:0] rd_val;
	logic [2:0] mode;
	logic enabled, spi_master, spi_slave, i2c_cfg;
	logic start_pulse, sck_rise, ss_high;
	logic done_evt, inc_evt, en_rise;

	// configuration decode; uart select overrides the mode field
	assign mode = ctrl_r[MODE_LSB +: 3];
	assign enabled = ctrl_r[EN_BIT];
	assign uart_mode = ctrl_r[UART_BIT]; // RULE_04
	assign spi_master = !uart_mode && (mode <= MODE_TIMER); // RULE_04 RULE_01 RULE_02
	assign spi_slave = !uart_mode && (mode == MODE_SLAVE); // RULE_03
	assign i2c_cfg = !uart_mode && (mode == MODE_I2C); // RULE_03
	assign i2c_mode_active = enabled && i2c_cfg;
	assign i2c_debounce = i2c_cfg ? ctrl_r[DEB_LSB +: 2] : 2'h0; // RULE_05
	// unused mode 111 and uart mode leave the unit powered down
	assign unit_power_on = enabled && (spi_master || spi_slave || i2c_cfg); // RULE_06 RULE_03

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_have_r;
	assign s_axi_wready = !w_have_r;
	assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wr_ok = wr_fire && wlane_r;
	assign wr_ctrl = wr_ok && (awaddr_r == OFF_CTRL);
	assign wr_aux = wr_ok && (awaddr_r == OFF_AUX);
	assign wr_i2c = wr_ok && (awaddr_r == OFF_I2C);
	assign wr_int = wr_ok && (awaddr_r == OFF_INT_STATUS);
	assign wr_mask = wr_ok && (awaddr_r == OFF_INT_MASK);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_r <= 1'b0;
			awaddr_r <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_have_r <= 1'b1;
			awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
		end
		else if (wr_fire)
			aw_have_r <= 1'b0;
	end

	// only byte lane 0 carries register bits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_have_r <= 1'b0;
			wdata_r <= 8'h00;
			wlane_r <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_have_r <= 1'b1;
			wdata_r <= s_axi_wdata[7:0];
			wlane_r <= s_axi_wstrb[0];
		end
		else if (wr_fire)
			w_have_r <= 1'b0;
	end

	// response; unmapped addresses answer slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awaddr_r <= OFF_INT_MASK) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read mux; upper bits always zero
	assign rd_addr = {s_axi_araddr[7:2], 2'h0};
	always_comb
	begin
		rd_hit = 1'b1;
		unique case (rd_addr)
			OFF_CTRL: rd_val = ctrl_r; // RULE_09
			OFF_AUX: rd_val = {6'h00, aux_r};
			OFF_I2C: rd_val = {1'b0, i2c_flag_r, i2c_set_r};
			OFF_INT_STATUS: rd_val = {6'h00, int_status_r};
			OFF_INT_MASK: rd_val = {6'h00, int_mask_r};
			default:
			begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_val};
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// control register; hardware setting the incomplete flag beats a software clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_r <= CTRL_RESET;
		else
		begin
			if (wr_ctrl)
				ctrl_r <= wdata_r; // RULE_09 RULE_07
			if (inc_evt)
				ctrl_r[INC_BIT] <= 1'b1; // RULE_09 RULE_10
		end
	end

	// enabling never touches SPI settings, so software must set them up first
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			aux_r <= AUX_RESET;
		else
		begin
			if (wr_aux)
				aux_r <= wdata_r[1:0]; // RULE_07
			if (done_evt)
				aux_r[TRF_BIT] <= 1'b1; // RULE_10 RULE_11
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			en_q_r <= 1'b0;
		else
			en_q_r <= enabled;
	end
	assign en_rise = enabled && !en_q_r;

	// i2c settings survive enabling, the status flags go back to defaults
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			i2c_set_r <= I2C_SET_RESET;
		else if (wr_i2c)
			i2c_set_r <= wdata_r[ACK_BIT:TXS_BIT]; // RULE_08
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			i2c_flag_r <= I2C_FLAG_RESET;
		else if (en_rise && i2c_cfg)
			i2c_flag_r <= I2C_FLAG_RESET | (i2c_flag_set & {I2C_FLAG_N{i2c_mode_active}}); // RULE_08
		else
			i2c_flag_r <= i2c_flag_r | (i2c_flag_set & {I2C_FLAG_N{i2c_mode_active}});
	end

	// interrupts: write one to clear, a new event wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			int_status_r <= IRQ_RESET;
		else
			int_status_r <= (int_status_r & ~(wr_int ? wdata_r[1:0] : 2'h0))
				| {inc_evt, done_evt};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			int_mask_r <= IRQ_RESET;
		else if (wr_mask)
			int_mask_r <= wdata_r[1:0];
	end
	assign irq = |(int_status_r & int_mask_r);

	// pins from the peer pass two flops before use
	sync_two_ff #(
		.WIDTH(3)
	) u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({sub_clock_in, slave_select_pin_in, sclk_in}),
		.sync_out(pins_sync)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sck_q_r <= 1'b0;
		else
			sck_q_r <= pins_sync[0];
	end
	assign sck_rise = pins_sync[0] && !sck_q_r;
	// without its enable the select pin is ignored
	assign ss_high = aux_r[SSEN_BIT] && pins_sync[1]; // RULE_12

	spi_clock_gen u_clock_gen (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(state_r == XFER_MASTER),
		.mode(mode),
		.sub_level(pins_sync[2]),
		.match_pulse(period_match_pulse),
		.sclk_r(gen_sclk),
		.bit_done(gen_bit_done)
	);

	assign start_pulse = wr_aux && wdata_r[START_BIT];
	// an aborted slave transfer raises both flags in the same cycle
	assign inc_evt = (state_r == XFER_SLAVE) && enabled && ss_high; // RULE_10
	assign done_evt = inc_evt
		|| ((state_r == XFER_MASTER) && gen_bit_done && (bit_cnt_r == BITS_PER_XFER - 4'h1))
		|| ((state_r == XFER_SLAVE) && sck_rise && (bit_cnt_r == BITS_PER_XFER - 4'h1));

	// transfer sequencer; dropping enable or mode abandons a transfer silently
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= XFER_IDLE;
			bit_cnt_r <= 4'h0;
		end
		else
		begin
			unique case (state_r)
				XFER_IDLE:
				begin
					bit_cnt_r <= 4'h0;
					if (start_pulse && enabled && spi_master)
						state_r <= XFER_MASTER; // RULE_01 RULE_02
					else if (enabled && spi_slave && sck_rise
						&& !(aux_r[SSEN_BIT] && pins_sync[1]))
					begin
						state_r <= XFER_SLAVE; // RULE_03
						bit_cnt_r <= 4'h1;
					end
				end
				XFER_MASTER:
				begin
					if (!enabled || !spi_master || done_evt)
						state_r <= XFER_IDLE;
					else if (gen_bit_done)
						bit_cnt_r <= bit_cnt_r + 4'h1;
				end
				XFER_SLAVE:
				begin
					if (!enabled || !spi_slave || done_evt)
						state_r <= XFER_IDLE;
					else if (sck_rise)
						bit_cnt_r <= bit_cnt_r + 4'h1;
				end
			endcase
		end
	end

	// pin drive; nothing drives while disabled
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sclk_out <= 1'b0;
			slave_select_pin_out <= 1'b1;
		end
		else
		begin
			sclk_out <= gen_sclk;
			slave_select_pin_out <= state_r != XFER_MASTER;
		end
	end
	assign sclk_oe = enabled && spi_master; // RULE_06
	assign slave_select_pin_oe = enabled && spi_master && aux_r[SSEN_BIT]; // RULE_12 RULE_06

	property p_oe_off;
		@(posedge aclk) disable iff (!aresetn)
		!enabled |-> !sclk_oe && !slave_select_pin_oe && !unit_power_on;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pins driven while disabled"); // RULE_06

	property p_div4;
		@(posedge aclk) disable iff (!aresetn)
		(state_r == XFER_MASTER && mode == MODE_DIV4 && $changed(gen_sclk) && enabled)
			##1 (state_r == XFER_MASTER) |-> $stable(gen_sclk) ##1 $changed(gen_sclk);
	endproperty
	a_div4: assert property (p_div4) else $error("divide by four period wrong"); // RULE_01

	property p_timer_half;
		@(posedge aclk) disable iff (!aresetn)
		(state_r == XFER_MASTER && mode == MODE_TIMER && !period_match_pulse) |=> $stable(gen_sclk);
	endproperty
	a_timer_half: assert property (p_timer_half) else $error("timer clock moved without match"); // RULE_02

	property p_unused;
		@(posedge aclk) disable iff (!aresetn)
		(mode == 3'h7) |-> !unit_power_on && !sclk_oe && state_r == XFER_IDLE ##1 1'b1;
	endproperty
	a_unused: assert property (p_unused) else $error("unused mode active"); // RULE_03

	property p_uart;
		@(posedge aclk) disable iff (!aresetn)
		uart_mode |-> !spi_master && !spi_slave && !i2c_mode_active;
	endproperty
	a_uart: assert property (p_uart) else $error("uart select did not win"); // RULE_04

	property p_debounce;
		@(posedge aclk) disable iff (!aresetn)
		!i2c_cfg |-> i2c_debounce == 2'h0;
	endproperty
	a_debounce: assert property (p_debounce) else $error("debounce leaked outside i2c"); // RULE_05

	property p_enable_keeps;
		@(posedge aclk) disable iff (!aresetn)
		$rose(enabled) && !i2c_cfg && !$past(wr_aux) |-> aux_r[SSEN_BIT] == $past(aux_r[SSEN_BIT]);
	endproperty
	a_enable_keeps: assert property (p_enable_keeps) else $error("enable altered settings"); // RULE_07

	property p_i2c_clear;
		@(posedge aclk) disable iff (!aresetn)
		(en_rise && i2c_cfg && i2c_flag_set == '0 && !wr_i2c)
			|=> i2c_flag_r == I2C_FLAG_RESET && i2c_set_r == $past(i2c_set_r);
	endproperty
	a_i2c_clear: assert property (p_i2c_clear) else $error("i2c enable handling wrong"); // RULE_08

	property p_inc_with_trf;
		@(posedge aclk) disable iff (!aresetn)
		inc_evt |=> ctrl_r[INC_BIT] && aux_r[TRF_BIT] && int_status_r == 2'h3 ##1 1'b1;
	endproperty
	a_inc_with_trf: assert property (p_inc_with_trf) else $error("incomplete without trf"); // RULE_10

	property p_sw_inc;
		@(posedge aclk) disable iff (!aresetn)
		wr_ctrl && wdata_r[INC_BIT] && !done_evt && !aux_r[TRF_BIT] |=> !aux_r[TRF_BIT];
	endproperty
	a_sw_inc: assert property (p_sw_inc) else $error("software write set trf"); // RULE_11

	property p_ss_float;
		@(posedge aclk) disable iff (!aresetn)
		!aux_r[SSEN_BIT] |-> !slave_select_pin_oe && !inc_evt;
	endproperty
	a_ss_float: assert property (p_ss_float) else $error("select pin used while off"); // RULE_12
endmodule : serial_mode_ctrl

//--- sim/spi_peer_model.sv
// external spi master peer: supplies serial clock and select in slave mode
module spi_peer_model
(
	input wire logic aclk,
	input wire logic go,
	input wire logic [3:0] edges,
	output logic sclk,
	output logic sel_n,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// select idles high through its pull-up, clock stands still between frames
	initial
	begin
		sclk = 1'h0;
		sel_n = 1'h1;
		busy = 1'h0;
	end
	// one frame per go; fewer than 8 edges lifts select early on purpose
	always @(posedge aclk)
	begin
		if (go)
		begin
			busy <= 1'h1;
			sel_n <= 1'h0;
			repeat (4) @(posedge aclk);
			repeat (edges)
			begin
				repeat (6) @(posedge aclk);
				sclk <= 1'h1;
				repeat (6) @(posedge aclk);
				sclk <= 1'h0;
			end
			repeat (4) @(posedge aclk);
			sel_n <= 1'h1;
			busy <= 1'h0;
		end
	end
endmodule : spi_peer_model

//--- sim/tb_serial_mode_control_spi.sv
// self-checking bench for the serial mode control unit
module tb_serial_mode_control_spi;
	timeunit 1ns;
	timeprecision 1ps;
	import serial_mode_pkg::*;
	localparam int WMASK[5] = '{32'hFF, 32'h3, 32'h3, 32'h0, 32'h3};
	localparam int GAPS[5] = '{32'h4, 32'h10, 32'h40, 32'hA, 32'hC};
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, prev = 1'h0;
	logic [1:0] bresp, rresp, deb;
	logic [31:0] rdata;
	logic sclk_out, sclk_oe, ss_out, ss_oe, sub_clk = 1'h0, match = 1'h0;
	logic [4:0] flag_set = 5'h00;
	logic uart_mode, power_on, i2c_act, irq, peer_go = 1'h0, peer_sclk, peer_sel_n, peer_busy;
	logic [3:0] peer_edges = 4'h8;
	logic [7:0] rnd = 8'h07;
	int num_errors = 0, checks_done = 0, cyc = 0, rises = 0, last = 0, gap = 0;
	int shadow[5];

	always #20 aclk = ~aclk;

	serial_mode_ctrl i_serial_mode_ctrl (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sclk_in(peer_sclk),
		.sclk_out(sclk_out), .sclk_oe(sclk_oe), .slave_select_pin_in(peer_sel_n),
		.slave_select_pin_out(ss_out), .slave_select_pin_oe(ss_oe), .sub_clock_in(sub_clk),
		.period_match_pulse(match), .i2c_flag_set(flag_set), .uart_mode(uart_mode),
		.unit_power_on(power_on), .i2c_mode_active(i2c_act), .i2c_debounce(deb), .irq(irq));

	spi_peer_model i_spi_peer_model (.aclk(aclk), .go(peer_go), .edges(peer_edges),
		.sclk(peer_sclk), .sel_n(peer_sel_n), .busy(peer_busy));

	// alternative clock sources run free; serial clock rises are timed here
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc % 5 == 4)
			sub_clk <= ~sub_clk;
		match <= (cyc % 6 == 5);
		prev <= sclk_out;
		if (sclk_out === 1'h1)
			chk(ss_out, 32'h0, "select high in frame");
		if (sclk_out && !prev)
		begin
			rises <= rises + 1;
			gap <= cyc - last;
			last <= cyc;
		end
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task automatic hang(input string m);
		num_errors++;
		$display("[ERR] %0t timeout %s", $time, m);
		close_out();
	endtask : hang

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
			if (bvalid)
				break;
		end
		if (n == 100)
			hang("write");
		bready <= 1'h0;
		chk(bresp, (a > OFF_INT_MASK) ? RESP_SLVERR : RESP_OKAY, "bresp");
		if (a == OFF_INT_STATUS)
			shadow[3] &= ~d;
		else if (a <= OFF_INT_MASK)
			shadow[a[4:2]] = d & WMASK[a[4:2]];
		@(posedge aclk);
	endtask : wr

	task automatic rd_raw(input logic [7:0] a, output logic [31:0] d);
		int n;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'h0;
			if (rvalid)
				break;
		end
		if (n == 100)
			hang("read");
		rready <= 1'h0;
		d = rdata;
		chk(rresp, (a > OFF_INT_MASK) ? RESP_SLVERR : RESP_OKAY, "rresp");
		@(posedge aclk);
	endtask : rd_raw

	task automatic rd(input logic [7:0] a);
		logic [31:0] d;
		rd_raw(a, d);
		chk(d, (a > OFF_INT_MASK) ? 32'h0 : shadow[a[4:2]], "read");
	endtask : rd

	// peer frame, then poll status until the expected bit appears
	task automatic peer_run(input logic [3:0] e, input int b);
		logic [31:0] d;
		int k;
		peer_edges <= e;
		peer_go <= 1'h1;
		@(posedge aclk);
		peer_go <= 1'h0;
		@(posedge aclk);
		for (k = 0; k < 500 && peer_busy; k++)
			@(posedge aclk);
		if (k == 500)
			hang("peer busy");
		for (k = 0; k < 20; k++)
		begin
			rd_raw(OFF_INT_STATUS, d);
			if (d[b])
				break;
		end
		if (k == 20)
			hang("slave frame");
	endtask : peer_run

	initial
	begin
		logic [31:0] d;
		int m, u, k;
		shadow = '{32'hE0, 32'h0, 32'h0, 32'h0, 32'h0};
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		// reset contents, unmapped offset included
		for (k = 0; k < 6; k++)
			rd(8'(k * 4));
		wr(8'h14, 32'hFF);
		chk(power_on, 32'h0, "power at reset");
		// every mode with and without uart select, random debounce
		wr(OFF_AUX, 32'h1);
		for (m = 0; m < 8; m++)
			for (u = 0; u < 2; u++)
			begin
				rnd = lfsr(rnd);
				d = {24'h0, m[2:0], u[0], rnd[1:0], 2'h2};
				wr(OFF_CTRL, d);
				chk(sclk_oe, m < 5 && u == 0, "master drive");
				chk(ss_oe, m < 5 && u == 0, "select drive");
				chk(power_on, m != 7 && u == 0, "power");
				chk(i2c_act, m == 6 && u == 0, "i2c");
				chk(deb, (m == 6 && u == 0) ? rnd[1:0] : 2'h0, "debounce");
				chk(uart_mode, u[0], "uart");
				rd(OFF_CTRL);
			end
		wr(OFF_CTRL, 32'h0);
		chk({sclk_oe, ss_oe, power_on}, 32'h0, "disabled pins");
		// enabling in spi configuration keeps settings
		wr(OFF_CTRL, 32'h0C);
		wr(OFF_CTRL, 32'h0E);
		rd(OFF_CTRL);
		rd(OFF_AUX);
		// select enable off: select pin floats while the clock pin still drives
		wr(OFF_AUX, 32'h0);
		chk(ss_oe, 32'h0, "select floats");
		chk(sclk_oe, 32'h1, "clock still driven");
		wr(OFF_AUX, 32'h1);
		// master transfer from each clock source
		wr(OFF_INT_MASK, 32'h3);
		for (m = 0; m < 5; m++)
		begin
			wr(OFF_CTRL, {24'h0, m[2:0], 5'h02});
			rises = 0;
			wr(OFF_AUX, 32'h5);
			for (k = 0; k < 3000 && irq !== 1'h1; k++)
				@(posedge aclk);
			if (k == 3000)
				hang("master done");
			chk(rises, 32'h8, "sclk rises");
			chk(gap, GAPS[m], "sclk period");
			shadow[1] |= 2;
			shadow[3] |= 1;
			rd(OFF_AUX);
			wr(OFF_INT_STATUS, 32'h3);
			wr(OFF_AUX, 32'h1);
			chk(irq, 32'h0, "irq cleared");
		end
		// i2c enable keeps settings but clears flags
		wr(OFF_CTRL, 32'hC0);
		wr(OFF_I2C, 32'h3);
		wr(OFF_CTRL, 32'hC2);
		flag_set <= 5'h1F;
		@(posedge aclk);
		flag_set <= 5'h00;
		shadow[2] = 32'h7F;
		rd(OFF_I2C);
		wr(OFF_CTRL, 32'hC0);
		wr(OFF_CTRL, 32'hC2);
		shadow[2] = 32'h3;
		rd(OFF_I2C);
		// slave frame with done masked, then a frame cut short
		wr(OFF_CTRL, 32'hA2);
		wr(OFF_INT_MASK, 32'h2);
		peer_run(4'h8, 0);
		chk(irq, 32'h0, "masked irq");
		shadow[1] |= 2;
		shadow[3] |= 1;
		rd(OFF_CTRL);
		rd(OFF_AUX);
		wr(OFF_INT_MASK, 32'h3);
		chk(irq, 32'h1, "unmasked irq");
		wr(OFF_INT_STATUS, 32'h3);
		wr(OFF_AUX, 32'h1);
		peer_run(4'h3, 1);
		shadow[0] |= 1;
		shadow[1] |= 2;
		shadow[3] |= 3;
		rd(OFF_CTRL);
		rd(OFF_AUX);
		rd(OFF_INT_STATUS);
		// software-set incomplete flag leaves transfer flags alone
		wr(OFF_INT_STATUS, 32'h3);
		wr(OFF_AUX, 32'h1);
		wr(OFF_CTRL, 32'hA2);
		wr(OFF_CTRL, 32'hA3);
		rd(OFF_CTRL);
		rd(OFF_AUX);
		rd(OFF_INT_STATUS);
		wr(OFF_CTRL, 32'hA2);
		rd(OFF_CTRL);
		close_out();
	end
endmodule : tb_serial_mode_control_spi
